// ### rtl/i2c_master_command_queue.sv
// Queued two-wire bus master: instruction queue, bit engine, response queue.
// Assumes external pull-ups on both wires and slaves that never stretch SCL.
`timescale 1ns/100ps

// ============================================================================
// Synchronous FIFO with valid/ready on both sides
module stream_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr, rptr, next_wptr, next_rptr;
  logic [AW:0] count, next_count;
  logic push, pop;

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem[rptr];

  always_comb begin
    next_wptr = push ? wptr + 1'b1 : wptr;
    next_rptr = pop ? rptr + 1'b1 : rptr;
    case ({push, pop})
      2'b10: next_count = count + 1'b1;
      2'b01: next_count = count - 1'b1;
      default: next_count = count;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
    end else begin
      wptr <= next_wptr;
      rptr <= next_rptr;
      count <= next_count;
    end
  end

  // Storage needs no reset; only the pointers and count define what is valid.
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wptr] <= in_data;
    end
  end
endmodule

// ============================================================================
// Top level
// Function
// RL1: Instruction ready drops while the instruction queue is full.
// RL2: Ready returns the clock after an entry frees; held instruction taken.
// RL3: SDA released during the slave acknowledge slot, SCL still pulsed.
// RL4: Slave pulls SDA low to acknowledge, leaves it high otherwise.
// RL5: Stalled response output holds its word and valid flag.
// RL6: Responses queued in bus order, one word per ack or read byte.
// RL7: Works with an SCL period of only four system clocks.
// RL8: No clock stretching; SCL timing comes purely from the period count.
// RL9: Instruction codes 0 to 8 as listed; other codes do nothing.
// RL10: Read bytes report code 5; ack slots code 8, bit 0 set on no-ack.
// RL11: Instruction ready also drops while the response queue is full.
// RL12: SCL period is a cycle count; SDA moves a set count after SCL falls.
module i2c_master_command_queue #(
  parameter logic [15:0] period_cycles = i2c_cmdq_pkg::SCL_PERIOD_CYCLES,
  parameter logic [15:0] sda_shift_cycles = i2c_cmdq_pkg::SDA_SHIFT_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic instr_valid,
  output logic instr_ready,
  input wire i2c_cmdq_pkg::cmd_t instr,
  output logic resp_valid,
  input wire logic resp_ready,
  output i2c_cmdq_pkg::cmd_t resp,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe
);
  import i2c_cmdq_pkg::*;

  // Valid setting needs period_cycles >= 4 and 1 <= shift < period/2.
  localparam logic [15:0] HALF = period_cycles >> 1;
  localparam logic [15:0] SHIFT_AT = sda_shift_cycles - 16'h0001;
  localparam logic [15:0] LAST = period_cycles - 16'h0001;

  logic ififo_in_ready, ififo_valid, ififo_pop;
  logic rfifo_in_ready, push_valid;
  cmd_t ififo_data, push_data;
  logic [11:0] ififo_raw, rfifo_raw;

  eng_state_t state, next_state;
  logic [3:0] cur_op, next_op;
  logic [15:0] cnt, next_cnt;
  logic [3:0] bits, next_bits;
  logic [7:0] shreg, next_shreg;
  logic sda_lvl, next_sda_lvl;
  logic engaged, next_engaged;
  logic next_scl_oe, next_sda_oe;
  logic sda_meta, sda_sync;
  logic slot_end;

  // ==========================================================================
  // Queues
  assign instr_ready = ififo_in_ready & rfifo_in_ready; // RL1 RL11
  assign ififo_data = cmd_t'(ififo_raw);
  assign resp = cmd_t'(rfifo_raw);

  stream_fifo #(.WIDTH($bits(cmd_t)), .DEPTH(FIFO_DEPTH)) u_instr_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(instr_valid & rfifo_in_ready),
    .in_ready(ififo_in_ready),
    .in_data(instr),
    .out_valid(ififo_valid),
    .out_ready(ififo_pop),
    .out_data(ififo_raw)
  );

  // The pop is gated on response room, so a response is never dropped.
  stream_fifo #(.WIDTH($bits(cmd_t)), .DEPTH(FIFO_DEPTH)) u_resp_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(push_valid),
    .in_ready(rfifo_in_ready),
    .in_data(push_data),
    .out_valid(resp_valid),
    .out_ready(resp_ready),
    .out_data(rfifo_raw)
  );

  // ==========================================================================
  // Pin synchroniser
  always_ff @(posedge clk) begin
    if (rst) begin
      sda_meta <= 1'b1;
      sda_sync <= 1'b1;
    end else begin
      sda_meta <= sda_in;
      sda_sync <= sda_meta;
    end
  end

  // ==========================================================================
  // Bit engine
  // Each slot is one SCL period: low for the first half, high for the rest.
  // The line is read at the slot end; the two-stage synchroniser means the
  // value seen was on the wire two clocks earlier.
  assign slot_end = (state == ST_SLOT) && (cnt == LAST); // RL12
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;

  always_comb begin
    next_state = state;
    next_op = cur_op;
    next_cnt = cnt;
    next_bits = bits;
    next_shreg = shreg;
    next_sda_lvl = sda_lvl;
    next_engaged = engaged;
    ififo_pop = 1'b0;
    push_valid = 1'b0;
    push_data = '{op: cur_op, data: 8'h00};
    case (state)
      ST_IDLE: begin
        if (ififo_valid && rfifo_in_ready) begin
          ififo_pop = 1'b1;
          next_op = ififo_data.op;
          next_shreg = ififo_data.data;
          next_cnt = 16'h0000;
          case (ififo_data.op) // RL9
            OP_RESET: begin
              next_engaged = 1'b0;
              next_sda_lvl = 1'b1;
            end
            OP_START, OP_STOP, OP_MASTER_ACK, OP_MASTER_NOACK,
            OP_SLAVE_ACK: begin
              next_state = ST_SLOT;
              next_bits = ONE_BIT;
              next_engaged = 1'b1;
            end
            OP_ADDR, OP_WDATA, OP_RDATA: begin
              next_state = ST_SLOT;
              next_bits = BYTE_BITS;
              next_engaged = 1'b1;
            end
            default: begin
            end
          endcase
        end
      end
      ST_SLOT: begin
        next_cnt = cnt + 16'h0001; // RL8
        if (cnt == SHIFT_AT) begin // RL12
          case (cur_op)
            OP_START: next_sda_lvl = 1'b1;
            OP_STOP: next_sda_lvl = 1'b0;
            OP_ADDR, OP_WDATA: next_sda_lvl = shreg[7];
            OP_MASTER_ACK: next_sda_lvl = 1'b0;
            default: next_sda_lvl = 1'b1; // RL3
          endcase
        end
        if (cnt == HALF) begin
          if (cur_op == OP_START) begin
            next_sda_lvl = 1'b0;
          end else if (cur_op == OP_STOP) begin
            next_sda_lvl = 1'b1;
          end
        end
        if (slot_end) begin
          next_cnt = 16'h0000;
          next_shreg = {shreg[6:0], sda_sync};
          next_bits = bits - 4'h1;
          if (bits == ONE_BIT) begin
            next_state = ST_IDLE;
            if (cur_op == OP_RDATA) begin // RL6 RL10
              push_valid = 1'b1;
              push_data = '{op: OP_RDATA, data: {shreg[6:0], sda_sync}};
            end else if (cur_op == OP_SLAVE_ACK) begin // RL4 RL10
              push_valid = 1'b1;
              push_data = '{op: OP_SLAVE_ACK, data: {7'h00, sda_sync}};
            end else if (cur_op == OP_STOP) begin
              next_engaged = 1'b0;
            end
          end
        end
      end
      default: next_state = ST_IDLE;
    endcase
    next_scl_oe = next_engaged && (next_state == ST_SLOT) &&
                  (next_cnt < HALF); // RL7
    next_sda_oe = next_engaged && !next_sda_lvl;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= ST_IDLE;
      cur_op <= OP_RESET;
      cnt <= 16'h0000;
      bits <= 4'h0;
      shreg <= 8'h00;
      sda_lvl <= 1'b1;
      engaged <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      state <= next_state;
      cur_op <= next_op;
      cnt <= next_cnt;
      bits <= next_bits;
      shreg <= next_shreg;
      sda_lvl <= next_sda_lvl;
      engaged <= next_engaged;
      scl_oe <= next_scl_oe;
      sda_oe <= next_sda_oe;
    end
  end

  // ==========================================================================
  // Checks
  chk_full_ready: assert property ( // RL1
    @(posedge clk) disable iff (rst)
    !ififo_in_ready |-> !instr_ready)
    else $error("instruction ready high while queue full");

  chk_ready_return: assert property ( // RL2
    @(posedge clk) disable iff (rst)
    (ififo_pop && !ififo_in_ready && rfifo_in_ready) |=>
    (instr_ready || !rfifo_in_ready))
    else $error("instruction ready late after an entry freed");

  chk_ack_release: assert property ( // RL3
    @(posedge clk) disable iff (rst)
    (state == ST_SLOT && cnt > sda_shift_cycles &&
     (cur_op == OP_SLAVE_ACK || cur_op == OP_RDATA)) |-> !sda_oe)
    else $error("SDA driven during a released slot");

  chk_resp_hold: assert property ( // RL5
    @(posedge clk) disable iff (rst)
    (resp_valid && !resp_ready) |=> (resp_valid && $stable(resp)))
    else $error("stalled response changed");

  chk_ack_report: assert property ( // RL10
    @(posedge clk) disable iff (rst)
    (slot_end && cur_op == OP_SLAVE_ACK) |->
    (push_valid && push_data.op == OP_SLAVE_ACK &&
     push_data.data == {7'h00, sda_sync}))
    else $error("ack slot report malformed");

  chk_read_order: assert property ( // RL6
    @(posedge clk) disable iff (rst)
    push_valid |-> (slot_end && bits == ONE_BIT &&
                    (cur_op == OP_RDATA || cur_op == OP_SLAVE_ACK)))
    else $error("response pushed outside a finished slot");

  chk_scl_phase: assert property ( // RL7
    @(posedge clk) disable iff (rst)
    (state == ST_SLOT && engaged) |-> (scl_oe == (cnt < HALF)))
    else $error("SCL phase does not match period count");

  chk_sda_shift: assert property ( // RL12
    @(posedge clk) disable iff (rst)
    (!$past(rst) && $changed(sda_lvl) && $past(state) == ST_SLOT) |->
    ($past(cnt) == SHIFT_AT || $past(cnt) == HALF))
    else $error("SDA moved at the wrong slot offset");

  chk_no_room: assert property ( // RL11
    @(posedge clk) disable iff (rst)
    !rfifo_in_ready |-> (!instr_ready && !ififo_pop))
    else $error("instruction taken with response queue full");

  chk_stop_release: assert property ( // RL9
    @(posedge clk) disable iff (rst)
    (slot_end && bits == ONE_BIT && cur_op == OP_STOP) |=>
    (!scl_oe && !sda_oe))
    else $error("bus not released after stop");
endmodule

// ### rtl/i2c_cmdq_pkg.sv
// Shared constants and carrier types for the queued two-wire bus master.
// Assumes a 100 MHz system clock and pull-ups on both bus wires.
package i2c_cmdq_pkg;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCL_PERIOD_NS = 10000;
  localparam int SDA_SHIFT_NS = 500;
  localparam logic [15:0] SCL_PERIOD_CYCLES =
    16'(SCL_PERIOD_NS / CLK_PERIOD_NS);
  localparam logic [15:0] SDA_SHIFT_CYCLES =
    16'((SDA_SHIFT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ==========================================================================
  // Queues
  localparam int FIFO_DEPTH = 16;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] ONE_BIT = 4'h1;

  // ==========================================================================
  // Instruction and response codes
  localparam logic [3:0] OP_RESET = 4'h0;
  localparam logic [3:0] OP_START = 4'h1;
  localparam logic [3:0] OP_STOP = 4'h2;
  localparam logic [3:0] OP_ADDR = 4'h3;
  localparam logic [3:0] OP_WDATA = 4'h4;
  localparam logic [3:0] OP_RDATA = 4'h5;
  localparam logic [3:0] OP_MASTER_ACK = 4'h6;
  localparam logic [3:0] OP_MASTER_NOACK = 4'h7;
  localparam logic [3:0] OP_SLAVE_ACK = 4'h8;

  typedef struct packed {
    logic [3:0] op;
    logic [7:0] data;
  } cmd_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_SLOT = 1'b1
  } eng_state_t;

endpackage

// ### bench/i2c_slave_model.sv
// Behavioural two-wire slave: acks one address, keeps the last written
// byte and returns two fixed bytes on reads. Assumes pull-ups in the bench.
`timescale 1ns/100ps

module i2c_slave_model #(
  parameter logic [6:0] dev_addr = 7'h50,
  parameter logic [7:0] rd0 = 8'hBF,
  parameter logic [7:0] rd1 = 8'h7C
) (
  input wire logic scl,
  input wire logic sda,
  output logic pull,
  output logic [7:0] last_wr
);
  logic act = 1'b0;
  logic first, rd, sel;
  logic [7:0] sh, rbyte;
  int bitn, rdcnt;

  initial pull = 1'b0;
  initial last_wr = 8'h00;

  // ==========================================================================
  // Frame edges
  always @(negedge sda) if (scl === 1'b1) begin
    act = 1'b1;
    first = 1'b1;
    rd = 1'b0;
    sel = 1'b0;
    bitn = 0;
    rdcnt = 0;
    pull = 1'b0;
  end
  always @(posedge sda) if (scl === 1'b1) begin
    act = 1'b0;
    pull = 1'b0;
  end

  // ==========================================================================
  // Bits: sample while SCL is high, change SDA only while it is low.
  always @(posedge scl) if (act) begin
    if (bitn < 8) sh = {sh[6:0], sda};
    else if (rd && sda) sel = 1'b0;
    bitn++;
  end
  always @(negedge scl) if (act) begin
    if (bitn == 8) begin
      if (first) begin
        sel = (sh[7:1] == dev_addr);
        rd = sh[0];
      end else if (!rd && sel) last_wr = sh;
      pull = sel && (first || !rd);
    end else if (bitn == 9) begin
      bitn = 0;
      first = 1'b0;
      if (rd && sel) begin
        rbyte = (rdcnt == 0) ? rd0 : rd1;
        rdcnt++;
      end
      pull = rd && sel && !rbyte[7];
    end else pull = rd && sel && !rbyte[7-bitn];
  end
endmodule

// ### bench/test_i2c_master_command_queue.sv
// Self-checking bench for the queued two-wire master with a slave model.
// Assumes the package constants and pull-ups modelled on both wires.
`timescale 1ns/100ps

module test_i2c_master_command_queue;
  import i2c_cmdq_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic instr_valid = 1'b0;
  logic resp_ready = 1'b0;
  logic instr_ready, resp_valid, scl_out, scl_oe, sda_out, sda_oe, pull;
  logic scl_q = 1'b0;
  cmd_t instr = '0;
  cmd_t resp, hold;
  logic [7:0] last_wr;
  logic [19:0] rows [19];
  wire scl_w = !scl_oe;
  wire sda_w = !(sda_oe || pull);
  int err_total = 0;
  int total_checks = 0;
  int cyc = 0;
  int gap = 0;
  int min_gap = 999;
  int n;
  // Second master with the shortest legal slot and no slave on its wires.
  logic fast_valid = 1'b0;
  logic fast_take = 1'b0;
  logic fast_q = 1'b0;
  logic fast_ready, fast_rvalid, fast_scl_oe, fast_sda_oe;
  cmd_t fast_instr = '0;
  cmd_t fast_resp;
  logic [11:0] fast_rows [4];
  wire fast_scl = !fast_scl_oe;
  wire fast_sda = !fast_sda_oe;
  int fast_falls = 0;
  int fast_lows = 0;

  always #5 clk = !clk;

  i2c_master_command_queue #(
    .period_cycles(16'h0004),
    .sda_shift_cycles(16'h0001)
  ) uut_fast (
    .clk(clk), .rst(rst), .instr_valid(fast_valid),
    .instr_ready(fast_ready), .instr(fast_instr), .resp_valid(fast_rvalid),
    .resp_ready(fast_take), .resp(fast_resp), .scl_in(fast_scl),
    .scl_out(), .scl_oe(fast_scl_oe), .sda_in(fast_sda),
    .sda_out(), .sda_oe(fast_sda_oe)
  );

  i2c_master_command_queue #(
    .period_cycles(16'h000C),
    .sda_shift_cycles(16'h0002)
  ) uut (
    .clk(clk), .rst(rst), .instr_valid(instr_valid),
    .instr_ready(instr_ready), .instr(instr), .resp_valid(resp_valid),
    .resp_ready(resp_ready), .resp(resp), .scl_in(scl_w),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe(sda_oe)
  );

  i2c_slave_model slave (.scl(scl_w), .sda(sda_w), .pull(pull),
    .last_wr(last_wr));

  // ==========================================================================
  // Reporting
  task automatic check(string what, logic [11:0] seen, logic [11:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Shortest gap between SCL falls shows the slot length; run is cut short.
  always @(posedge clk) begin
    cyc++;
    gap++;
    if (scl_oe && !scl_q) begin
      if (gap < min_gap) min_gap = gap;
      gap = 0;
    end
    scl_q = scl_oe;
    if (fast_scl_oe && !fast_q) fast_falls++;
    if (fast_scl_oe) fast_lows++;
    fast_q = fast_scl_oe;
    if (cyc == 5000) begin
      err_total++;
      tally_and_finish();
    end
  end

  // ==========================================================================
  // Handshakes: values read just after an edge are those it sampled.
  task automatic push(cmd_t c);
    instr_valid <= 1'b1;
    instr <= c;
    n = 0;
    do begin @(posedge clk); n++; end while (!instr_ready && n < 400);
    if (!instr_ready) err_total++;
  endtask

  task automatic get(cmd_t exp);
    resp_ready <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (!resp_valid && n < 400);
    if (!resp_valid) err_total++;
    check("resp", resp, exp);
  endtask

  // ==========================================================================
  // Main sequence. Row layout: code, operand, expected response byte.
  initial begin
    rows = '{20'h10000, 20'h3A000, 20'h80000, 20'h43C00, 20'h80000,
      20'h10000, 20'h3A100, 20'h80000, 20'h500BF, 20'h60000, 20'h5007C,
      20'h70000, 20'h20000, 20'h10000, 20'h3B000, 20'h80001, 20'h20000,
      20'hF5A00, 20'h00000};
    fast_rows = '{12'h100, 12'h3A0, 12'h800, 12'h200};
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check("reset", {instr_ready, resp_valid, scl_oe, sda_oe}, 12'h008);
    check("pin levels", {scl_out, sda_out}, 12'h000);
    foreach (rows[i]) push(rows[i][19:8]);
    instr_valid <= 1'b0;
    n = 0;
    while (!resp_valid && n < 2000) begin @(posedge clk); n++; end
    hold = resp;
    check("first word", hold, 12'h800);
    repeat (6) @(posedge clk);
    check("stall word", resp, hold);
    check("stall valid", resp_valid, 12'h001);
    foreach (rows[i])
      if (rows[i][19:16] inside {OP_RDATA, OP_SLAVE_ACK})
        get({rows[i][19:16], rows[i][7:0]});
    resp_ready <= 1'b0;
    check("written byte", last_wr, 12'h03C);
    check("slot length", min_gap, 12'h00C);
    // Four-clock slots with no slave present: the ack slot reads high.
    foreach (fast_rows[i]) begin
      fast_valid <= 1'b1;
      fast_instr <= fast_rows[i];
      do @(posedge clk); while (!fast_ready);
    end
    fast_valid <= 1'b0;
    fast_take <= 1'b1;
    n = 0;
    while (!fast_rvalid && n < 200) begin @(posedge clk); n++; end
    check("fast ack", fast_resp, 12'h801);
    repeat (40) @(posedge clk);
    check("fast slots", fast_falls, 12'h00B);
    check("fast low", fast_lows, 12'h016);
    check("fast idle", {fast_scl_oe, fast_sda_oe}, 12'h000);
    // Response queue full while the instruction queue still has room.
    for (int i = 0; i < 16; i++) push(12'h800);
    instr_valid <= 1'b0;
    n = 0;
    while (instr_ready && n < 1000) begin @(posedge clk); n++; end
    repeat (20) @(posedge clk);
    check("resp full", instr_ready, 12'h000);
    resp_ready <= 1'b1;
    @(posedge clk);
    check("no-ack word", resp, 12'h801);
    resp_ready <= 1'b0;
    @(posedge clk);
    check("ready back", instr_ready, 12'h001);
    for (int i = 0; i < 15; i++) get(12'h801);
    resp_ready <= 1'b0;
    // Instruction queue full: one word in the engine plus sixteen queued.
    instr_valid <= 1'b1;
    instr <= 12'h4A5;
    n = 0;
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      n += instr_ready;
    end
    check("accepted", n, 12'h011);
    n = 0;
    while (!instr_ready && n < 200) begin @(posedge clk); n++; end
    check("refill", n < 120, 12'h001);
    instr_valid <= 1'b0;
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    @(posedge clk);
    check("mid reset", {instr_ready, resp_valid, scl_oe, sda_oe}, 12'h008);
    tally_and_finish();
  end
endmodule
